// *** dv/txser_asic_model.sv ***
// system asic model feeding parallel words on the word clock
`timescale 1ns/1ps
module txser_asic_model (
   input  wire logic        i_mclk,
   input  wire logic        i_word_clock_out,
   input  wire logic        i_valid,
   input  wire logic [15:0] i_word,
   output logic      [15:0] o_word,
   output logic             o_wclk,
   output logic             o_taken
);
   logic [4:0] cnt = 5'h00;
   logic       prev = 1'b0;
   logic       pend = 1'b0;

   initial begin
      o_word  = 16'h0000;
      o_wclk  = 1'b0;
      o_taken = 1'b0;
   end

   // word changes at slot start, rising edge at count 8 of 32 keeps setup and hold wide
   always @(posedge i_mclk) begin
      prev    <= i_word_clock_out;
      o_taken <= 1'b0;
      cnt     <= cnt + 5'h01;
      if (i_word_clock_out && !prev) begin
         cnt     <= 5'h01;
         pend    <= i_valid;
         o_taken <= i_valid;
         o_word  <= i_valid ? i_word : ~o_word; // idle lines keep moving
      end
      if (cnt == 5'h08)
         o_wclk <= pend;
      if (cnt == 5'h18)
         o_wclk <= 1'b0;
   end
endmodule

// *** dv/txser_asserts.sv ***
// assertion checker for the transmit word serializer
`timescale 1ns/1ps
module txser_asserts
   import txser_pkg::*;
#(
   parameter int WORD_W = 16
) (
   input wire logic              i_mclk,
   input wire logic              i_rst,
   input wire txser_apb_req_type i_apb,
   input wire txser_apb_rsp_type o_apb,
   input wire logic [WORD_W-1:0] i_parallel_tx_word,
   input wire logic              i_word_clock_in,
   input wire logic              i_clock_multiplier_locked,
   input wire logic              o_serial_tx_out,
   input wire logic              o_serial_bit_clock,
   input wire logic              o_word_clock_out,
   input wire logic              o_tx_lock_lost_n,
   input wire logic              o_irq
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   // setup cycle of an apb transfer
   sequence s_setup;
      i_apb.psel && !i_apb.penable;
   endsequence
   // word clock: 16 cycles high, 16 low
   sequence s_word_cycle;
      ##16 $fell(o_word_clock_out) ##16 $rose(o_word_clock_out);
   endsequence

   a_ready_answer: assert property (s_setup |=> o_apb.pready)
      else $error("no answer after setup");
   a_ready_single: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("answer held too long");
   a_ready_cause: assert property (o_apb.pready |-> i_apb.penable)
      else $error("answer outside access phase");
   a_err_unmapped: assert property (s_setup ##0 i_apb.paddr > 12'h00C
      |=> o_apb.pslverr && o_apb.prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_bitclk_half: assert property (
      $rose(o_serial_bit_clock) |=> $fell(o_serial_bit_clock))
      else $error("bit clock not half rate");
   a_tx_on_edge: assert property (
      $changed(o_serial_tx_out) |-> $rose(o_serial_bit_clock))
      else $error("serial data moved off bit clock");
   a_word_period: assert property (
      $rose(o_word_clock_out) |-> s_word_cycle)
      else $error("word clock not bit clock over 16");
   a_lock_gain: assert property (
      $rose(i_clock_multiplier_locked) |-> ##3 $rose(o_tx_lock_lost_n))
      else $error("lock flag late on gain");
   a_lock_loss: assert property (
      $fell(i_clock_multiplier_locked) |-> ##3 $fell(o_tx_lock_lost_n))
      else $error("lock flag late on loss");
endmodule

bind txser_top txser_asserts #(.WORD_W(WORD_W)) u_asserts (
   .i_mclk(i_mclk),
   .i_rst(i_rst),
   .i_apb(i_apb),
   .o_apb(o_apb),
   .i_parallel_tx_word(i_parallel_tx_word),
   .i_word_clock_in(i_word_clock_in),
   .i_clock_multiplier_locked(i_clock_multiplier_locked),
   .o_serial_tx_out(o_serial_tx_out),
   .o_serial_bit_clock(o_serial_bit_clock),
   .o_word_clock_out(o_word_clock_out),
   .o_tx_lock_lost_n(o_tx_lock_lost_n),
   .o_irq(o_irq)
);

// *** dv/txser_tb_top.sv ***
// self-checking bench for the transmit word serializer
`timescale 1ns/1ps
`include "txser_consts.svh"
module txser_tb_top;
   import txser_pkg::*;
   logic              i_mclk = 1'b0;
   logic              i_rst = 1'b1;
   logic              lock = 1'b1;
   logic              valid = 1'b0;
   logic       [15:0] word = 16'h0000;
   logic       [15:0] p_word;
   logic              p_wclk, taken, wc_q, bc_q, tx, bc, wc, lol_n, irq;
   txser_apb_req_type req = '0;
   txser_apb_rsp_type rsp;
   logic       [31:0] rdat;
   logic              rerr;
   logic       [1:0]  ctls [3] = '{2'b10, 2'b11, 2'b00};
   int                errors = 0;
   int                n_checks = 0;

   txser_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_apb(req),
      .o_apb(rsp), .i_parallel_tx_word(p_word), .i_word_clock_in(p_wclk),
      .i_clock_multiplier_locked(lock), .o_serial_tx_out(tx),
      .o_serial_bit_clock(bc), .o_word_clock_out(wc),
      .o_tx_lock_lost_n(lol_n), .o_irq(irq));
   txser_asic_model asic (.i_mclk(i_mclk), .i_word_clock_out(wc),
      .i_valid(valid), .i_word(word), .o_word(p_word), .o_wclk(p_wclk),
      .o_taken(taken));

   // 20 MHz clock and edge history for rise detection
   always #25 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      wc_q <= wc;
      bc_q <= bc;
   end

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // one apb transfer; values read before this edge's updates land
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int t;
      @(posedge i_mclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_mclk);
      req.penable <= 1'b1;
      for (t = 0; t < 20 && rsp.pready !== 1'b1; t++)
         @(posedge i_mclk);
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req  <= '0;
      if (t == 20) begin
         errors++;
         stop_test;
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask

   // expected stream: squelch gives zeros, order picks first bit
   function automatic logic [15:0] ser(input logic [15:0] w,
                                       input logic [1:0] c);
      logic [15:0] r;
      for (int i = 0; i < 16; i++)
         r[i] = c[1] & (c[0] ? w[15-i] : w[i]);
      return r;
   endfunction

   // 16 serial bits of the slot starting at the next word clock rise
   task automatic collect(output logic [15:0] b);
      int n;
      n = 0;
      b = 16'h0000;
      for (int t = 0; t < 99 && n < 16; t++) begin
         @(posedge i_mclk);
         if ((n > 0 || (wc && !wc_q)) && bc && !bc_q) begin
            b[n] = tx;
            n++;
         end
      end
      if (n < 16) begin
         errors++;
         stop_test;
      end
   endtask

   task automatic send2(input logic [15:0] w0, w1, input logic [1:0] c);
      logic [15:0] b;
      int          t;
      apb(1'b1, `TXSER_ADDR_CTRL, {30'h0, c});
      word  <= w0;
      valid <= 1'b1;
      for (t = 0; t < 99 && taken !== 1'b1; t++)
         @(posedge i_mclk);
      if (t == 99) begin
         errors++;
         stop_test;
      end
      word <= w1;
      collect(b);
      valid <= 1'b0;
      chk(b, ser(w0, c));
      collect(b);
      chk(b, ser(w1, c));
      collect(b);
      chk(b, 16'h0000);
   endtask

   task automatic scen_lock;
      apb(1'b1, `TXSER_ADDR_STATUS, 32'h0000_0007);
      apb(1'b1, `TXSER_ADDR_MASK, 32'h0000_0001);
      lock <= 1'b0;
      repeat (6) @(posedge i_mclk);
      chk({lol_n, irq}, 32'h0000_0001);
      lock <= 1'b1;
      repeat (6) @(posedge i_mclk);
      rd(`TXSER_ADDR_STATUS, 32'h0000_0005);
      apb(1'b1, `TXSER_ADDR_STATUS, 32'h0000_0001);
      repeat (2) @(posedge i_mclk);
      chk({lol_n, irq}, 32'h0000_0002);
      rd(`TXSER_ADDR_STATUS, 32'h0000_0004);
   endtask

   task automatic scen_clkdis;
      int h;
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, `TXSER_ADDR_CTRL, p ? 32'h0000_0002 : 32'h0000_0006);
         repeat (2) @(posedge i_mclk);
         h = 0;
         repeat (32) begin
            @(posedge i_mclk);
            h += bc;
         end
         chk(h, p ? 16 : 0);
      end
   endtask

   // reset, registers, events, then the serial paths
   initial begin
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(`TXSER_ADDR_CTRL, 32'h0000_0002);
      rd(`TXSER_ADDR_MASK, 32'h0000_0000);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      chk({31'h0, rerr}, 32'h0000_0001);
      chk(rdat, 32'h0000_0000);
      scen_lock;
      for (int k = 0; k < 3; k++)
         send2(16'hA5C3 ^ 16'(k), 16'h0F01 << k, ctls[k]);
      rd(`TXSER_ADDR_STATUS, 32'h0000_0004);
      apb(1'b0, `TXSER_ADDR_STATE, 32'h0000_0000);
      chk(rdat & 32'h0000_0001, 32'h0000_0001);
      scen_clkdis;
      stop_test;
   end
endmodule

// *** hdl/txser_consts.svh ***
// constants for the transmit word serializer
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
// Functional notes
// - partner presents 16-bit word; captured on word clock rising edge
// - captured words leave as one serial stream, changing on bit clock rise
// - bit order select 0 sends bit 0 first, then ascending to 15
// - bit order select 1 sends bit 15 first, then descending to 0
// - squelch low forces every serial output bit to zero
// - squelch high sends serialized data unaltered
// - lock-lost output low while multiplier unlocked, high once locked
// - word clock output is the serial bit clock divided by 16
// - clock disable high turns serial clock output off; low keeps it
`ifndef TXSER_CONSTS_SVH
`define TXSER_CONSTS_SVH

//------------------------------------------------------------------
// register byte addresses
//------------------------------------------------------------------
`define TXSER_ADDR_CTRL    12'h000
`define TXSER_ADDR_STATUS  12'h004
`define TXSER_ADDR_MASK    12'h008
`define TXSER_ADDR_STATE   12'h00C

//------------------------------------------------------------------
// field positions
//------------------------------------------------------------------
`define TXSER_CTRL_ORDER    0
`define TXSER_CTRL_SQLCH_N  1
`define TXSER_CTRL_CLK_DIS  2
`define TXSER_EV_LOCK_LOST  0
`define TXSER_EV_OVERRUN    1
`define TXSER_EV_LOCKED     2

//------------------------------------------------------------------
// reset values and counts
//------------------------------------------------------------------
`define TXSER_CTRL_RESET   3'h2
`define TXSER_EV_RESET     3'h0
`define TXSER_WORD_BITS    16
`define TXSER_HALF_WORD    8
`define TXSER_SYNC_STAGES  2

`endif

// *** hdl/txser_pkg.sv ***
// types shared by the transmit word serializer
package txser_pkg;

   // software control bits
   typedef struct packed {
      logic clk_disable;
      logic squelch_n;
      logic bit_order;
   } txser_ctrl_type;

   // apb request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } txser_apb_req_type;

   // apb answer bundle
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } txser_apb_rsp_type;

   // serializer state, one-hot
   typedef enum logic [1:0] {
      TXSER_WAIT = 2'b01,
      TXSER_RUN  = 2'b10
   } txser_state_type;

endpackage

// *** hdl/txser_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module txser_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         meta   <= '0;
         o_sync <= '0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// *** hdl/txser_top.sv ***
// transmit 16:1 word serializer with apb control and interrupt
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "txser_consts.svh"
module txser_top #(
   parameter int WORD_W = `TXSER_WORD_BITS
) (
   input  wire logic                       i_mclk,
   input  wire logic                       i_rst,
   input  wire txser_pkg::txser_apb_req_type i_apb,
   output txser_pkg::txser_apb_rsp_type    o_apb,
   input  wire logic [WORD_W-1:0]          i_parallel_tx_word,
   input  wire logic                       i_word_clock_in,
   input  wire logic                       i_clock_multiplier_locked,
   output logic                            o_serial_tx_out,
   output logic                            o_serial_bit_clock,
   output logic                            o_word_clock_out,
   output logic                            o_tx_lock_lost_n,
   output logic                            o_irq
);
   import txser_pkg::*;

   localparam int CW = $clog2(WORD_W);
   // counter value of the last bit of a slot, where the next word loads
   localparam logic [CW-1:0] LAST_BIT = CW'(WORD_W - 1);

   //---------------------------------------------------------------
   // declarations
   //---------------------------------------------------------------
   txser_ctrl_type    ctrl;
   txser_state_type   state;
   logic [2:0]        status;
   logic [2:0]        mask;
   logic [2:0]        ev_set;
   logic [WORD_W-1:0] word_sync;
   logic              wclk_sync;
   logic              lock_sync;
   logic              wclk_prev;
   logic              lock_prev;
   logic [WORD_W-1:0] hold_word;
   logic              hold_full;
   logic [WORD_W-1:0] shreg;
   logic [CW-1:0]     bit_cnt;
   logic              bclk;
   logic              bit_edge;
   logic              word_edge;
   logic              load_now;
   logic              acc_wr;
   logic              setup;
   logic              running;
   logic [WORD_W-1:0] next_shreg;

   //---------------------------------------------------------------
   // pin synchronisers
   //---------------------------------------------------------------
   // data passes the same two stages as its clock so they stay aligned
   txser_sync #(.WIDTH(WORD_W + 2)) u_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async ({i_parallel_tx_word, i_word_clock_in,
                 i_clock_multiplier_locked}),
      .o_sync  ({word_sync, wclk_sync, lock_sync})
   );

   // edge history on the synchronised outputs only
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wclk_prev <= 1'b0;
         lock_prev <= 1'b0;
      end else begin
         wclk_prev <= wclk_sync;
         lock_prev <= lock_sync;
      end
   end

   // partner word clock rise, seen two stages late
   assign word_edge = wclk_sync & ~wclk_prev;

   //---------------------------------------------------------------
   // word capture
   //---------------------------------------------------------------
   // holding stage decouples the partner clock from the shift stage
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         hold_word <= '0;
      end else if (word_edge) begin
         hold_word <= word_sync;
      end
   end

   // full flag: a fresh capture wins over the load that empties it
   // a capture while the stage is still full and not loading is lost data and raises the overrun event
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         hold_full <= 1'b0;
      end else if (word_edge) begin
         hold_full <= 1'b1;
      end else if (load_now) begin
         hold_full <= 1'b0;
      end
   end

   //---------------------------------------------------------------
   // bit clock and word counter
   //---------------------------------------------------------------
   // one bit lasts two master cycles so the bit clock is a real flop
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         bclk <= 1'b0;
      end else begin
         bclk <= ~bclk;
      end
   end

   assign bit_edge = ~bclk;                       // bit clock about to rise
   assign load_now = bit_edge && (bit_cnt == LAST_BIT);

   // counting starts at the last bit so the first slot after reset is whole
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         bit_cnt <= LAST_BIT;
      end else if (bit_edge) begin
         bit_cnt <= bit_cnt + 1'b1;
      end
   end

   // gated bit clock driver
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_serial_bit_clock <= 1'b0;
      end else begin
         o_serial_bit_clock <= ~bclk & ~ctrl.clk_disable;
      end
   end

   // divide by 16: high for the first half of each word slot
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_word_clock_out <= 1'b0;
      end else if (bit_edge) begin
         o_word_clock_out <= (bit_cnt == CW'(WORD_W - 1)) ||
                             (bit_cnt < CW'(`TXSER_HALF_WORD - 1));
      end
   end

   //---------------------------------------------------------------
   // serializer state
   //---------------------------------------------------------------
   // wait until a first word loads; the state only drives the running readback
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= TXSER_WAIT;
      end else begin
         case (state)
            TXSER_WAIT: begin
               if (load_now && hold_full) begin
                  state <= TXSER_RUN;
               end
            end
            TXSER_RUN: begin
               state <= TXSER_RUN;
            end
            default: begin
               state <= TXSER_WAIT;
            end
         endcase
      end
   end

   //---------------------------------------------------------------
   // shift stage
   //---------------------------------------------------------------
   // order 0 shifts right from bit 0, order 1 shifts left from bit 15
   always_comb begin
      if (ctrl.bit_order) begin
         next_shreg = {shreg[WORD_W-2:0], 1'b0};
      end else begin
         next_shreg = {1'b0, shreg[WORD_W-1:1]};
      end
   end

   // an empty holding stage repeats nothing: the slot sends zeros
   // the load already sent the first bit, so every later edge shifts
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         shreg <= '0;
      end else if (load_now) begin
         shreg <= hold_full ? hold_word : '0;
      end else if (bit_edge) begin
         shreg <= next_shreg;
      end
   end

   // output moves only when the bit clock rises
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_serial_tx_out <= 1'b0;
      end else if (bit_edge) begin
         if (!ctrl.squelch_n) begin
            o_serial_tx_out <= 1'b0;
         end else if (bit_cnt == CW'(WORD_W - 1)) begin
            o_serial_tx_out <= ctrl.bit_order ? hold_word[WORD_W-1] & hold_full
                                              : hold_word[0] & hold_full;
         end else begin
            o_serial_tx_out <= ctrl.bit_order ? next_shreg[WORD_W-1]
                                              : next_shreg[0];
         end
      end
   end

   // lock indicator follows the synchronised multiplier lock
   // reset shows unlocked until the synchronised lock level arrives
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_tx_lock_lost_n <= 1'b0;
      end else begin
         o_tx_lock_lost_n <= lock_sync;
      end
   end

   //---------------------------------------------------------------
   // apb slave, one wait-free access phase
   //---------------------------------------------------------------
   // exact word match: unaligned and unmapped offsets never hit
   function automatic logic reg_hit(input logic [11:0] addr,
                                    input logic [11:0] offset);
      return addr == offset;
   endfunction

   // running flag for the state readback
   assign running = (state == TXSER_RUN);

   // setup forms the answer; access with pready commits a write
   assign setup  = i_apb.psel & ~i_apb.penable;
   assign acc_wr = i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready;

   // answer is registered in setup, presented in the first access cycle
   // reads have no side effects, so the answer can be formed early
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_apb <= '0;
      end else begin
         o_apb.pready  <= setup;
         o_apb.pslverr <= 1'b0;
         o_apb.prdata  <= '0;
         if (setup) begin
            case (i_apb.paddr)
               `TXSER_ADDR_CTRL:   o_apb.prdata <= {29'h0, ctrl};
               `TXSER_ADDR_STATUS: o_apb.prdata <= {29'h0, status};
               `TXSER_ADDR_MASK:   o_apb.prdata <= {29'h0, mask};
               `TXSER_ADDR_STATE:  o_apb.prdata <= {24'h0, 3'h0, bit_cnt,
                                                     running};
               default:            o_apb.pslverr <= 1'b1;
            endcase
         end
      end
   end

   // control and mask writes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ctrl <= `TXSER_CTRL_RESET;
         mask <= `TXSER_EV_RESET;
      end else if (acc_wr) begin
         if (reg_hit(i_apb.paddr, `TXSER_ADDR_CTRL)) begin
            ctrl <= i_apb.pwdata[2:0];
         end
         if (reg_hit(i_apb.paddr, `TXSER_ADDR_MASK)) begin
            mask <= i_apb.pwdata[2:0];
         end
      end
   end

   //---------------------------------------------------------------
   // interrupt status
   //---------------------------------------------------------------
   // one-cycle event pulses, one per status bit
   always_comb begin
      ev_set = '0;
      ev_set[`TXSER_EV_LOCK_LOST] = lock_prev & ~lock_sync;
      ev_set[`TXSER_EV_OVERRUN]   = word_edge & hold_full & ~load_now;
      ev_set[`TXSER_EV_LOCKED]    = ~lock_prev & lock_sync;
   end

   // write one to clear; an event in the clearing cycle still sets
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         status <= `TXSER_EV_RESET;
      end else if (acc_wr && reg_hit(i_apb.paddr, `TXSER_ADDR_STATUS)) begin
         status <= (status & ~i_apb.pwdata[2:0]) | ev_set;
      end else begin
         status <= status | ev_set;
      end
   end

   // level interrupt while any unmasked status bit stands
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(status & mask);
      end
   end
endmodule
